// [logic/ubbp_map.svh]
// Constants of the bit-bang parallel port: reset values and timing counts
`ifndef UBBP_MAP_SVH
`define UBBP_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define UBBP_CLK_NS      10
`define UBBP_WSTB_NS     20
`define UBBP_WSTB_CYC    ((`UBBP_WSTB_NS + `UBBP_CLK_NS - 1) / `UBBP_CLK_NS)
`define UBBP_SMPL_NS     1000
`define UBBP_SMPL_CYC    (`UBBP_SMPL_NS / `UBBP_CLK_NS)

// ----------------------------------------------------------------------
// Reset values and buffer depth
// ----------------------------------------------------------------------
`define UBBP_LINES_RST   8'h00
`define UBBP_DIR_RST     8'h00
`define UBBP_FIFO_DEPTH  16

`endif

// [logic/ubbp_pkg.sv]
// Types shared by the bit-bang parallel port
package ubbp_pkg;

   // Bit-bang variant
   typedef enum logic {UBBP_ASYNC, UBBP_SYNC} ubbp_mode_e;

   // Write-side sequencer states
   typedef enum logic {UBBP_IDLE, UBBP_STRB} ubbp_state_e;

   // One byte from the host with its per-line direction (1 = output)
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
   } ubbp_wr_s;

   // Channel configuration
   typedef struct packed {
      logic       enable;
      ubbp_mode_e mode;
      logic       wake_en;
   } ubbp_cfg_s;

endpackage : ubbp_pkg

// [logic/ubbp_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and registered flags
`timescale 1ns/1ps
`default_nettype none

module ubbp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   // Drain side
   output var  logic             out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;
   logic [AW-1:0]    rd_ptr_next;
   logic [WIDTH-1:0] head_next;

   // Pointer step with wrap at the last slot
   function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] ptr);
      return (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
   endfunction : ptr_step

   // Handshakes and occupancy
   assign push       = in_valid & in_ready;
   assign pop        = out_valid & out_ready;
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
   assign rd_ptr_next = pop ? ptr_step(rd_ptr_reg) : rd_ptr_reg;
   // Slot being filled becomes the head when nothing else is left
   assign head_next   = (push && (wr_ptr_reg == rd_ptr_next)) ? in_data : mem_reg[rd_ptr_next];

   // Storage and pointers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= ptr_step(wr_ptr_reg);
         end
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
      end
   end

   // Registered full and empty flags and head word
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else
      begin
         in_ready  <= (count_next != (AW+1)'(DEPTH));
         out_valid <= (count_next != '0);
         out_data  <= head_next;
      end
   end

endmodule : ubbp_fifo

`default_nettype wire

// [logic/ubbp_port.sv]
// One channel of the bit-bang parallel port between the USB data path and the pins
//
// Notes on behaviour
// - When enabled, each of the eight lines is set as input or output on its own.
// - Synchronous and asynchronous variants selectable, same pins for both.
// - Write strobe pulses low each time a host byte is driven out.
// - Read strobe rises once sampled byte has been passed toward the host.
// - While suspended with wakeup enabled, low pulse on input requests resume.
// - While active, low pulse on that input flushes transmit buffer next IN.
// - Suspend indicator reads high while suspended and low otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "ubbp_map.svh"

module ubbp_port #(
   parameter int DEPTH    = `UBBP_FIFO_DEPTH,
   parameter int WSTB_CYC = `UBBP_WSTB_CYC,
   parameter int SMPL_CYC = `UBBP_SMPL_CYC
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Configuration and USB state
   input  wire ubbp_pkg::ubbp_cfg_s cfg,
   input  wire logic               usb_suspended,
   // Host write stream
   input  wire logic               host_wr_valid,
   input  wire ubbp_pkg::ubbp_wr_s host_wr,
   output var  logic               host_wr_ready,
   // Upstream sample stream
   output var  logic               up_valid,
   output logic      [7:0]         up_data,
   input  wire logic               up_ready,
   // USB engine requests
   output var  logic               resume_req,
   output var  logic               flush_req,
   // Parallel lines
   input  wire logic [7:0]         port_lines_i,
   output var  logic [7:0]         port_lines_o,
   output var  logic [7:0]         port_lines_oe,
   // Strobes and indicators
   output var  logic               write_strobe_n,
   output var  logic               read_strobe_n,
   input  wire logic               send_now_wakeup_n,
   output var  logic               suspend_indicator_n
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   ubbp_pkg::ubbp_state_e state_reg;
   logic [7:0]  lines_s1_reg;
   logic [7:0]  lines_s2_reg;
   logic [7:0]  lines_s3_reg;
   logic [7:0]  lines_flt_reg;
   logic        sw_s1_reg;
   logic        sw_s2_reg;
   logic        sw_s3_reg;
   logic        sw_flt_reg;
   logic        sw_flt_d_reg;
   logic        sw_fall;
   logic [3:0]  wstb_cnt_reg;
   logic [7:0]  smpl_cnt_reg;
   logic        smpl_tick;
   logic        wr_fire;
   logic        capture;
   logic        pend_valid_reg;
   logic [7:0]  pend_data_reg;
   logic        pend_push;
   logic        pend_after;
   logic        fifo_in_ready;
   logic        strb_done;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------

   // Three-stage capture of lines and wakeup input
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lines_s1_reg <= 8'h00;
         lines_s2_reg <= 8'h00;
         lines_s3_reg <= 8'h00;
         sw_s1_reg    <= 1'b1;
         sw_s2_reg    <= 1'b1;
         sw_s3_reg    <= 1'b1;
      end
      else
      begin
         lines_s1_reg <= port_lines_i;
         lines_s2_reg <= lines_s1_reg;
         lines_s3_reg <= lines_s2_reg;
         sw_s1_reg    <= send_now_wakeup_n;
         sw_s2_reg    <= sw_s1_reg;
         sw_s3_reg    <= sw_s2_reg;
      end
   end

   // Accept a change only when stages two and three agree
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lines_flt_reg <= 8'h00;
         sw_flt_reg    <= 1'b1;
         sw_flt_d_reg  <= 1'b1;
      end
      else
      begin
         lines_flt_reg <= (lines_s2_reg & ~(lines_s2_reg ^ lines_s3_reg))
                        | (lines_flt_reg & (lines_s2_reg ^ lines_s3_reg));
         if (sw_s2_reg == sw_s3_reg)
            sw_flt_reg <= sw_s2_reg;
         sw_flt_d_reg <= sw_flt_reg;
      end
   end

   assign sw_fall = sw_flt_d_reg & ~sw_flt_reg;

   // ----------------------------------------------------------------------
   // Host write sequencer
   // ----------------------------------------------------------------------
   assign wr_fire   = host_wr_valid & host_wr_ready;
   assign strb_done = (state_reg == ubbp_pkg::UBBP_STRB) && (wstb_cnt_reg == 4'h0);

   // Drive lines and time the write strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg      <= ubbp_pkg::UBBP_IDLE;
         port_lines_o   <= `UBBP_LINES_RST;
         port_lines_oe  <= `UBBP_DIR_RST;
         write_strobe_n <= 1'b1;
         wstb_cnt_reg   <= 4'h0;
      end
      else
      begin
         unique case (state_reg)
            ubbp_pkg::UBBP_IDLE:
            begin
               if (wr_fire)
               begin
                  port_lines_o   <= host_wr.data;
                  port_lines_oe  <= host_wr.dir;
                  write_strobe_n <= 1'b0;
                  wstb_cnt_reg   <= 4'(WSTB_CYC - 1);
                  state_reg      <= ubbp_pkg::UBBP_STRB;
               end
            end
            ubbp_pkg::UBBP_STRB:
            begin
               if (wstb_cnt_reg == 4'h0)
               begin
                  write_strobe_n <= 1'b1;
                  state_reg      <= ubbp_pkg::UBBP_IDLE;
               end
               else
                  wstb_cnt_reg <= wstb_cnt_reg - 4'h1;
            end
         endcase
         if (!cfg.enable)
            port_lines_oe <= 8'h00;
      end
   end

   // Ready for the next host byte
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         host_wr_ready <= 1'b0;
      else
         host_wr_ready <= cfg.enable && !pend_after
                        && ((state_reg == ubbp_pkg::UBBP_IDLE) ? !wr_fire : strb_done);
   end

   // ----------------------------------------------------------------------
   // Sampling toward the host
   // ----------------------------------------------------------------------

   // Free-running sample timer for the asynchronous variant
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         smpl_cnt_reg <= 8'h00;
      else if (smpl_cnt_reg == 8'h00)
         smpl_cnt_reg <= 8'(SMPL_CYC - 1);
      else
         smpl_cnt_reg <= smpl_cnt_reg - 8'h01;
   end

   assign smpl_tick = (smpl_cnt_reg == 8'h00);

   // sample per write or per tick
   assign capture = cfg.enable && !pend_valid_reg
                  && ((cfg.mode == ubbp_pkg::UBBP_SYNC) ? wr_fire : smpl_tick);
   assign pend_push  = pend_valid_reg & fifo_in_ready;
   assign pend_after = pend_valid_reg ? !pend_push : capture;

   // Hold one sample and drive the read strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_valid_reg <= 1'b0;
         pend_data_reg  <= 8'h00;
         read_strobe_n  <= 1'b1;
      end
      else if (capture)
      begin
         pend_valid_reg <= 1'b1;
         pend_data_reg  <= lines_flt_reg;
         read_strobe_n  <= 1'b0;
      end
      else if (pend_push)
      begin
         pend_valid_reg <= 1'b0;
         read_strobe_n  <= 1'b1;
      end
   end

   // Transmit buffer toward the USB engine
   ubbp_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_txbuf (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (pend_valid_reg),
      .in_data   (pend_data_reg),
      .in_ready  (fifo_in_ready),
      .out_valid (up_valid),
      .out_data  (up_data),
      .out_ready (up_ready)
   );

   // ----------------------------------------------------------------------
   // Wakeup, flush and suspend indicator
   // ----------------------------------------------------------------------

   // One-cycle requests on a low pulse of the wakeup input
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         resume_req <= 1'b0;
         flush_req  <= 1'b0;
      end
      else
      begin
         resume_req <= sw_fall && usb_suspended && cfg.wake_en;
         flush_req  <= sw_fall && !usb_suspended;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         suspend_indicator_n <= 1'b0;
      else
         suspend_indicator_n <= usb_suspended;
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_lines_off;
      @(posedge clk) disable iff (!rst_b)
      !cfg.enable |=> (port_lines_oe == 8'h00);
   endproperty
   a_lines_off: assert property (p_lines_off)
      else $error("lines driven while port disabled");

   property p_sync_sample;
      @(posedge clk) disable iff (!rst_b)
      (wr_fire && cfg.mode == ubbp_pkg::UBBP_SYNC)
         |=> (!read_strobe_n && pend_data_reg == $past(lines_flt_reg));
   endproperty
   a_sync_sample: assert property (p_sync_sample)
      else $error("synchronous write took no sample");

   property p_wr_strobe;
      @(posedge clk) disable iff (!rst_b)
      wr_fire |=> (!write_strobe_n && port_lines_o == $past(host_wr.data))
         ##1 !write_strobe_n ##1 write_strobe_n;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe)
      else $error("write strobe not a two-cycle low pulse with data");

   property p_rd_rise;
      @(posedge clk) disable iff (!rst_b)
      $rose(read_strobe_n) |-> $past(pend_push);
   endproperty
   a_rd_rise: assert property (p_rd_rise)
      else $error("read strobe rose without a buffered byte");

   property p_resume;
      @(posedge clk) disable iff (!rst_b)
      (sw_fall && usb_suspended && cfg.wake_en) |=> (resume_req && !flush_req);
   endproperty
   a_resume: assert property (p_resume)
      else $error("wakeup pulse gave no resume request");

   property p_flush;
      @(posedge clk) disable iff (!rst_b)
      $fell(sw_s3_reg) ##1 (sw_s3_reg == 1'b0) && !usb_suspended ##1 !usb_suspended
         |-> flush_req;
   endproperty
   a_flush: assert property (p_flush)
      else $error("send-now pulse gave no flush request");

   property p_susp_ind;
      @(posedge clk) disable iff (!rst_b)
      ##1 (suspend_indicator_n == $past(usb_suspended));
   endproperty
   a_susp_ind: assert property (p_susp_ind)
      else $error("suspend indicator does not follow suspend");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      !wr_fire |=> $stable(port_lines_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output lines changed without a host write");

endmodule : ubbp_port

`default_nettype wire

// [tb/ubbp_ext_model.sv]
// Model of the external logic on the parallel lines and wakeup pin
`timescale 1ns/1ps
`default_nettype none

module ubbp_ext_model (
   // Clock
   input  wire logic       clk,
   // Port side
   input  wire logic [7:0] port_lines_o,
   input  wire logic [7:0] port_lines_oe,
   output var  logic [7:0] port_lines_i,
   output var  logic       send_now_wakeup_n
);
   logic [7:0] ext_val;  // Level driven on released lines

   // Wire level: port drive wins where enabled
   always_comb port_lines_i = (port_lines_o & port_lines_oe) | (ext_val & ~port_lines_oe);

   // Idle levels
   initial
   begin
      ext_val           = 8'h00;
      send_now_wakeup_n = 1'h1;
   end

   task automatic wake_pulse();
      @(negedge clk);
      send_now_wakeup_n = 1'h0;
      repeat (4) @(negedge clk);
      send_now_wakeup_n = 1'h1;
   endtask : wake_pulse
endmodule : ubbp_ext_model
`default_nettype wire

// [tb/ubbp_port_tb.sv]
// Self-checking testbench of one bit-bang port channel
`timescale 1ns/1ps
`default_nettype none

module ubbp_port_tb;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic                clk;
   logic                rst_b;
   ubbp_pkg::ubbp_cfg_s cfg;
   logic                usb_suspended;
   logic                host_wr_valid;
   ubbp_pkg::ubbp_wr_s  host_wr;
   logic                host_wr_ready;
   logic                up_valid;
   logic [7:0]          up_data;
   logic                up_ready;
   logic                resume_req;
   logic                flush_req;
   logic [7:0]          lines_i;
   logic [7:0]          lines_o;
   logic [7:0]          lines_oe;
   logic                wstb_n;
   logic                rstb_n;
   logic                wake_n;
   logic                susp_n;
   logic                rs_first;  // Read strobe one cycle after a write
   int                  errors;
   int                  samples_checked;

   ubbp_port #(.DEPTH(16), .SMPL_CYC(8)) dut (
      .clk(clk), .rst_b(rst_b), .cfg(cfg), .usb_suspended(usb_suspended),
      .host_wr_valid(host_wr_valid), .host_wr(host_wr), .host_wr_ready(host_wr_ready),
      .up_valid(up_valid), .up_data(up_data), .up_ready(up_ready),
      .resume_req(resume_req), .flush_req(flush_req), .port_lines_i(lines_i),
      .port_lines_o(lines_o), .port_lines_oe(lines_oe), .write_strobe_n(wstb_n),
      .read_strobe_n(rstb_n), .send_now_wakeup_n(wake_n), .suspend_indicator_n(susp_n));

   ubbp_ext_model ext (
      .clk(clk), .port_lines_o(lines_o), .port_lines_oe(lines_oe),
      .port_lines_i(lines_i), .send_now_wakeup_n(wake_n));

   // 100 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   // Offer one byte, check strobe and lines; entered and left at negedge
   task automatic wr(input logic [7:0] d, input logic [7:0] dir, output logic ok);
      int n;
      ok = 1'h0;
      host_wr.data = d;
      host_wr.dir = dir;
      host_wr_valid = 1'h1;
      for (n = 0; n < 40 && !ok; n++)
      begin
         if (host_wr_ready === 1'h1)
            ok = 1'h1;
         @(negedge clk);
      end
      host_wr_valid = 1'h0;
      if (ok)
      begin
         rs_first = rstb_n;
         check("wstb_c1", wstb_n, 1'h0);
         check("lines_o", lines_o, d);
         check("lines_oe", lines_oe, dir);
         @(negedge clk);
         check("wstb_c2", wstb_n, 1'h0);
         @(negedge clk);
         check("wstb_c3", wstb_n, 1'h1);
      end
   endtask : wr

   // Take one upstream word
   task automatic pop(output logic [7:0] d);
      int n;
      up_ready = 1'h1;
      for (n = 0; n < 60 && up_valid !== 1'h1; n++)
         @(negedge clk);
      check("up_valid", up_valid, 1'h1);
      d = up_data;
      @(negedge clk);
      up_ready = 1'h0;
      @(negedge clk);
   endtask : pop

   task automatic drain();
      up_ready = 1'h1;
      repeat (30) @(negedge clk);
      up_ready = 1'h0;
      @(negedge clk);
   endtask : drain

   task automatic count_req(output int nres, output int nfl);
      nres = 0;
      nfl = 0;
      repeat (16)
      begin
         @(negedge clk);
         if (resume_req === 1'h1)
            nres++;
         if (flush_req === 1'h1)
            nfl++;
      end
   endtask : count_req

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_async();
      logic       ok;
      logic [7:0] d;
      cfg.mode = ubbp_pkg::UBBP_ASYNC;
      ext.ext_val = 8'hA5;
      wr(8'h00, 8'h00, ok);
      drain();
      repeat (3)
      begin
         pop(d);
         check("async_data", d, 8'hA5);
      end
      $display("test async done");
   endtask : t_async

   task automatic t_sync();
      logic       ok;
      logic [7:0] d;
      cfg.mode = ubbp_pkg::UBBP_SYNC;
      ext.ext_val = 8'h5A;
      drain();
      wr(8'h3C, 8'hF0, ok);
      repeat (20) @(negedge clk);
      check("hold_o", lines_o, 8'h3C);
      check("hold_oe", lines_oe, 8'hF0);
      wr(8'h00, 8'h00, ok);
      check("rstb_low", rs_first, 1'h0);
      check("rstb_rise", rstb_n, 1'h1);
      pop(d);
      check("sync_first", d, 8'h5A);
      pop(d);
      check("sync_data", d, 8'h3A);
      $display("test sync done");
   endtask : t_sync

   task automatic t_fill();
      logic       ok;
      logic [7:0] d;
      logic [7:0] q[$];
      int         k;
      ext.ext_val = 8'h77;
      drain();
      q.push_back(8'h77);
      ok = 1'h1;
      for (k = 1; k < 24 && ok; k++)
      begin
         wr(8'(k), 8'hFF, ok);
         if (ok)
            q.push_back(8'(k));
         repeat (8) @(negedge clk);
      end
      void'(q.pop_back());
      check("fill_count", q.size(), 17);
      check("fill_rstb", rstb_n, 1'h0);
      while (q.size() > 0)
      begin
         pop(d);
         check("fill_data", d, q.pop_front());
      end
      $display("test fill done");
   endtask : t_fill

   task automatic t_wake();
      int i;
      int r;
      int f;
      for (i = 0; i < 3; i++)
      begin
         usb_suspended = (i < 2);
         cfg.wake_en = (i == 0);
         repeat (2) @(negedge clk);
         check("susp_ind", susp_n, usb_suspended);
         fork
            ext.wake_pulse();
            count_req(r, f);
         join
         check("resume_cnt", r, (i == 0));
         check("flush_cnt", f, (i == 2));
      end
      $display("test wake done");
   endtask : t_wake

   task automatic t_off();
      cfg.enable = 1'h0;
      repeat (2) @(negedge clk);
      check("oe_off", lines_oe, 8'h00);
      check("o_kept", lines_o, 8'h11);
      check("ready_dis", host_wr_ready, 1'h0);
      $display("test off done");
   endtask : t_off

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      errors = 0;
      samples_checked = 0;
      rst_b = 1'h0;
      cfg = '0;
      usb_suspended = 1'h0;
      host_wr_valid = 1'h0;
      host_wr = '0;
      up_ready = 1'h0;
      rs_first = 1'h1;
      repeat (6) @(negedge clk);
      check("oe_rst", lines_oe, 8'h00);
      check("wstb_rst", wstb_n, 1'h1);
      check("rstb_rst", rstb_n, 1'h1);
      check("susp_rst", susp_n, 1'h0);
      rst_b = 1'h1;
      repeat (4) @(negedge clk);
      check("ready_off", host_wr_ready, 1'h0);
      cfg.enable = 1'h1;
      @(negedge clk);
      $display("test reset done");
      t_async();
      t_sync();
      t_fill();
      t_wake();
      t_off();
      summarize();
   end

   initial
   begin
      #100_000;
      errors++;
      summarize();
   end
endmodule : ubbp_port_tb
`default_nettype wire
